/* File: common/port_b_pkg.sv */
package port_b_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_DATA    = 8'h01;
    localparam logic [7:0]  IDX_DIR     = 8'h05;
    localparam logic [7:0]  IDX_PULL    = 8'h11;
    localparam logic [7:0]  IDX_OPT     = 8'h20;
    localparam logic [7:0]  IDX_NONE    = 8'hff;

    // Field layout
    localparam logic [7:0]  IMPL_MASK   = 8'h3f;
    localparam logic [7:0]  BONDED_MASK = 8'h0c;
    localparam int unsigned BOND_LO     = 2;
    localparam int unsigned BOND_HI     = 3;

    // Values after reset
    localparam logic [7:0]  DIR_RST     = 8'h00;
    localparam logic [7:0]  PULL_RST    = 8'h00;
    localparam logic [1:0]  PIN_RST     = 2'h0;
    localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

    // Bus encodings
    localparam logic [2:0]  HSIZE_WORD  = 3'h2;
    localparam logic        HRESP_OKAY  = 1'h0;

    typedef struct packed {
        logic       en;
        logic [7:0] idx;
        logic [7:0] data;
    } reg_wr_type;

    typedef struct packed {
        logic [1:0] oe;
        logic [1:0] out;
        logic [1:0] pull;
    } pin_ctl_type;

    function automatic logic [7:0] idx_of(input logic [31:0] addr);
        idx_of = (addr[31:10] == 22'h0 && addr[1:0] == 2'h0) ? addr[9:2] : IDX_NONE;
    endfunction

    function automatic logic [31:0] addr_of(input logic [7:0] idx);
        addr_of = {22'h0, idx, 2'h0};
    endfunction

endpackage

/* File: design/port_b_ahb_slave.sv */
`timescale 1ns/1ps
`default_nettype none

module port_b_ahb_slave (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   ce,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    input  wire logic [7:0]             rdata,
    output logic                        hreadyout,
    output logic [31:0]                 hrdata,
    output logic                        hresp,
    output port_b_pkg::reg_wr_type      wr,
    output logic                        rd_now,
    output logic [7:0]                  rd_idx
);
    import port_b_pkg::*;

    wire logic take;
    logic      wr_pend_q;
    logic      rd_pend_q;
    logic [7:0] idx_q;

    // Only whole-word transfers are taken; others complete OKAY with no effect
    assign take = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);

    assign wr.en   = wr_pend_q;
    assign wr.idx  = idx_q;
    assign wr.data = hwdata[7:0];
    assign rd_now  = rd_pend_q;
    assign rd_idx  = idx_q;

    // Reads take one wait state so a write just before is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            idx_q     <= IDX_NONE;
            hreadyout <= 1'b1;
            hrdata    <= RDATA_RST;
            hresp     <= HRESP_OKAY;
        end else if (ce) begin
            wr_pend_q <= take & hwrite;
            rd_pend_q <= take & ~hwrite;
            hreadyout <= ~(take & ~hwrite);
            hresp     <= HRESP_OKAY;
            if (take) begin
                idx_q <= idx_of(haddr);
            end
            if (rd_pend_q) begin
                hrdata <= {24'h0, rdata};
            end
        end
    end

endmodule // port_b_ahb_slave

`default_nettype wire

/* File: design/port_b_direction_pulldown.sv */
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none

module port_b_direction_pulldown (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic [1:0]  pin_in,
    output logic [1:0]       pin_out,
    output logic [1:0]       pin_oe,
    output logic [1:0]       pin_pulldown_en,
    input  wire logic        reset_pulldown_disable_option
);
    import port_b_pkg::*;

    reg_wr_type  wr;
    logic        rd_now;
    logic [7:0]  rd_idx;

    logic [7:0]  dir_q;
    logic [7:0]  dir_d;
    logic [7:0]  inhibit_q;
    logic [7:0]  inhibit_d;
    logic [7:0]  latch_q;
    logic [7:0]  latch_d;
    logic        force_q;
    logic        force_d;
    logic        strap_q;
    logic        cap_done_q;
    pin_ctl_type pins_q;
    pin_ctl_type pins_d;

    wire logic [7:0] pin_lvl;
    wire logic [7:0] rd_val;
    wire logic [7:0] oe_all;
    wire logic [7:0] pd_all;
    wire logic [7:0] opt_val;
    wire logic [7:0] rdata;
    wire logic       wr_data;
    wire logic       wr_dir;
    wire logic       wr_pull;

    port_b_ahb_slave u_bus (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .rdata     (rdata),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp),
        .wr        (wr),
        .rd_now    (rd_now),
        .rd_idx    (rd_idx)
    );

    // Unbonded bits have no pin; as inputs their pulldown holds them low
    assign pin_lvl = {4'h0, pin_in, 2'h0};

    assign wr_data = wr.en & (wr.idx == IDX_DATA);
    assign wr_dir  = wr.en & (wr.idx == IDX_DIR);
    assign wr_pull = wr.en & (wr.idx == IDX_PULL);

    // Latch takes every data write whatever the direction
    assign latch_d   = wr_data ? (wr.data & IMPL_MASK) : latch_q;
    // All six direction bits are storage, bonded or not
    assign dir_d     = wr_dir ? (wr.data & IMPL_MASK) : dir_q;
    // Only bonded positions keep an inhibit bit
    assign inhibit_d = wr_pull ? (wr.data & BONDED_MASK) : inhibit_q;
    // Reset option holds pulldowns off until software first writes the pulldown register
    assign force_d   = cap_done_q ? (force_q & ~wr_pull) : strap_q;

    port_b_pin_logic u_pin (
        .dir       (dir_d),
        .latch     (latch_d),
        .inhibit   (inhibit_d),
        .lvl       (pin_lvl),
        .force_off (force_d),
        .rd_val    (rd_val),
        .oe        (oe_all),
        .pd_en     (pd_all)
    );

    assign pins_d.oe   = oe_all[BOND_HI:BOND_LO];
    // Pin level is only driven while the buffer is on, so an input latch never leaks out
    assign pins_d.out  = latch_d[BOND_HI:BOND_LO] & oe_all[BOND_HI:BOND_LO];
    assign pins_d.pull = pd_all[BOND_HI:BOND_LO];

    assign opt_val = {6'h0, strap_q, force_q};

    // Pulldown register is write-only and reads zero; unmapped reads zero too
    assign rdata = (rd_idx == IDX_DATA) ? rd_val :
                   (rd_idx == IDX_DIR)  ? dir_q :
                   (rd_idx == IDX_OPT)  ? opt_val : 8'h00;

    assign pin_oe          = pins_q.oe;
    assign pin_out         = pins_q.out;
    assign pin_pulldown_en = pins_q.pull;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_q     <= DIR_RST;
            inhibit_q <= PULL_RST;
            pins_q    <= {PIN_RST, PIN_RST, PIN_RST};
        end else if (ce) begin
            dir_q     <= dir_d;
            inhibit_q <= inhibit_d;
            pins_q    <= pins_d;
        end
    end

    // Option is caught once after release, since a flop under reset may only load constants
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_done_q <= 1'b0;
            force_q    <= 1'b1;
        end else if (ce) begin
            cap_done_q <= 1'b1;
            force_q    <= force_d;
        end
    end

    always_ff @(posedge hclk) begin
        if (ce && !cap_done_q) begin
            strap_q <= reset_pulldown_disable_option;
        end
    end

    // No reset on the latch: its contents survive any reset
    always_ff @(posedge hclk) begin
        if (ce) begin
            latch_q <= latch_d;
        end
    end

    property p_dir_reset;
        @(posedge hclk) disable iff (!hresetn)
        !cap_done_q |-> (dir_q[BOND_HI:BOND_LO] == 2'h0) && (pin_oe == 2'h0);
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared by reset");

    property p_inhibit_reset;
        @(posedge hclk) disable iff (!hresetn)
        !cap_done_q |-> (inhibit_q[BOND_HI:BOND_LO] == 2'h0);
    endproperty
    a_inhibit_reset: assert property (p_inhibit_reset) else $error("inhibit not cleared");

    property p_oe_follows_dir;
        @(posedge hclk) disable iff (!hresetn)
        (ce && wr_dir) |=> (pin_oe == $past(wr.data[BOND_HI:BOND_LO])) &&
            (dir_q[BOND_HI:BOND_LO] == pin_oe);
    endproperty
    a_oe_follows_dir: assert property (p_oe_follows_dir) else $error("buffer enable wrong");

    property p_out_mode;
        @(posedge hclk) disable iff (!hresetn)
        (ce && cap_done_q) |=> (pin_oe == dir_q[BOND_HI:BOND_LO]) &&
            ((pin_oe & pin_out) == (pin_oe & latch_q[BOND_HI:BOND_LO]));
    endproperty
    a_out_mode: assert property (p_out_mode) else $error("output pin not showing latch");

    property p_read_output;
        @(posedge hclk) disable iff (!hresetn)
        (ce && rd_now && rd_idx == IDX_DATA) |=>
            ((hrdata[7:0] & $past(dir_q)) == ($past(latch_q) & $past(dir_q)));
    endproperty
    a_read_output: assert property (p_read_output) else $error("output bit read wrong");

    property p_read_input;
        @(posedge hclk) disable iff (!hresetn)
        (ce && rd_now && rd_idx == IDX_DATA) |=>
            ((hrdata[7:0] & ~$past(dir_q)) == ($past(pin_lvl) & ~$past(dir_q)));
    endproperty
    a_read_input: assert property (p_read_input) else $error("input bit read wrong");

    property p_latch_write;
        @(posedge hclk) disable iff (!hresetn)
        (ce && wr_data) |=> (latch_q == ($past(wr.data) & IMPL_MASK)) && $stable(dir_q);
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("latch write lost");

    property p_dir_storage;
        @(posedge hclk) disable iff (!hresetn)
        (ce && wr_dir) |=> ##1 ($past(ce && wr_dir) || dir_q == ($past(wr.data, 2) & IMPL_MASK));
    endproperty
    a_dir_storage: assert property (p_dir_storage) else $error("direction storage lost");

    property p_unbonded_pull;
        @(posedge hclk) disable iff (!hresetn)
        (pd_all & ~BONDED_MASK) == (~dir_d & IMPL_MASK & ~BONDED_MASK);
    endproperty
    a_unbonded_pull: assert property (p_unbonded_pull) else $error("unbonded pulldown off");

    property p_no_pull_on_output;
        @(posedge hclk) disable iff (!hresetn)
        (pin_oe & pin_pulldown_en) == 2'h0;
    endproperty
    a_no_pull_on_output: assert property (p_no_pull_on_output) else $error("pulldown on output");

    property p_inhibit_acts;
        @(posedge hclk) disable iff (!hresetn)
        (ce && wr_pull) |=> ((pin_pulldown_en & inhibit_q[BOND_HI:BOND_LO]) == 2'h0) && !force_q;
    endproperty
    a_inhibit_acts: assert property (p_inhibit_acts) else $error("inhibit ignored");

    property p_option_at_reset;
        @(posedge hclk) disable iff (!hresetn)
        $rose(cap_done_q) |-> (force_q == strap_q) && (!force_q || pin_pulldown_en == 2'h0);
    endproperty
    a_option_at_reset: assert property (p_option_at_reset) else $error("reset option ignored");

    property p_pull_formula;
        @(posedge hclk) disable iff (!hresetn)
        cap_done_q |-> pin_pulldown_en ==
            (~dir_q[BOND_HI:BOND_LO] & ~inhibit_q[BOND_HI:BOND_LO] & {2{~force_q}});
    endproperty
    a_pull_formula: assert property (p_pull_formula) else $error("pulldown enable wrong");

    property p_latch_kept;
        @(posedge hclk) disable iff (!hresetn)
        (ce && !wr_data) |=> $stable(latch_q);
    endproperty
    a_latch_kept: assert property (p_latch_kept) else $error("latch changed unwritten");

    property p_input_no_drive;
        @(posedge hclk) disable iff (!hresetn)
        (pin_out & ~pin_oe) == 2'h0;
    endproperty
    a_input_no_drive: assert property (p_input_no_drive) else $error("input pin driven");

    property p_oe_only_by_dir;
        @(posedge hclk) disable iff (!hresetn)
        (ce && !wr_dir) |=> $stable(pin_oe);
    endproperty
    a_oe_only_by_dir: assert property (p_oe_only_by_dir) else $error("enable moved");

    property p_forced_pull_off;
        @(posedge hclk) disable iff (!hresetn)
        (cap_done_q && force_q) |-> (pin_pulldown_en == 2'h0);
    endproperty
    a_forced_pull_off: assert property (p_forced_pull_off) else $error("forced pulldown on");

    property p_unbonded_no_inhibit;
        @(posedge hclk) disable iff (!hresetn)
        (inhibit_q & ~BONDED_MASK) == 8'h00;
    endproperty
    a_unbonded_no_inhibit: assert property (p_unbonded_no_inhibit) else $error("stray inhibit");

    property p_dir_width;
        @(posedge hclk) disable iff (!hresetn)
        (dir_q & ~IMPL_MASK) == 8'h00;
    endproperty
    a_dir_width: assert property (p_dir_width) else $error("direction upper bits set");

    property p_read_dir;
        @(posedge hclk) disable iff (!hresetn)
        (ce && rd_now && rd_idx == IDX_DIR) |=> (hrdata == {24'h0, $past(dir_q)});
    endproperty
    a_read_dir: assert property (p_read_dir) else $error("direction read wrong");

    property p_inhibit_only_by_write;
        @(posedge hclk) disable iff (!hresetn)
        (ce && !wr_pull) |=> $stable(inhibit_q);
    endproperty
    a_inhibit_only_by_write: assert property (p_inhibit_only_by_write) else $error("inhibit moved");

    property p_data_write_keeps_pins;
        @(posedge hclk) disable iff (!hresetn)
        (ce && wr_data) |=> $stable(pin_oe) && $stable(pin_pulldown_en);
    endproperty
    a_data_write_keeps_pins: assert property (p_data_write_keeps_pins) else $error("pins moved");

    property p_read_unbonded;
        @(posedge hclk) disable iff (!hresetn)
        (ce && rd_now && rd_idx == IDX_DATA) |=>
            ((hrdata[7:0] & ~$past(dir_q) & ~BONDED_MASK) == 8'h00);
    endproperty
    a_read_unbonded: assert property (p_read_unbonded) else $error("unbonded input not low");

endmodule // port_b_direction_pulldown

`default_nettype wire

/* File: design/port_b_pin_logic.sv */
`timescale 1ns/1ps
`default_nettype none

module port_b_pin_logic (
    input  wire logic [7:0] dir,
    input  wire logic [7:0] latch,
    input  wire logic [7:0] inhibit,
    input  wire logic [7:0] lvl,
    input  wire logic       force_off,
    output logic      [7:0] rd_val,
    output logic      [7:0] oe,
    output logic      [7:0] pd_en
);
    import port_b_pkg::*;

    wire logic [7:0] bond_off;

    // Direction bit drives the buffer enable directly
    assign oe       = dir & IMPL_MASK;
    // Output bits read the latch, input bits the pin level
    assign rd_val   = ((dir & latch) | (~dir & lvl)) & IMPL_MASK;
    // Unbonded bits have no inhibit, so only bonded bits can be turned off by inhibit or force_off
    assign bond_off = (inhibit | {8{force_off}}) & BONDED_MASK;
    assign pd_en    = ~dir & ~bond_off & IMPL_MASK;

endmodule // port_b_pin_logic

`default_nettype wire

/* File: testbench/port_b_board.sv */
`timescale 1ns/1ps
`default_nettype none

module port_b_board (
    input  wire logic       hclk,
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe,
    input  wire logic [1:0] pin_pulldown_en,
    input  wire logic [1:0] ext_en,
    input  wire logic [1:0] ext_val,
    output var  logic [1:0] pin_in
);
    logic [1:0] float_q;

    // A floating pin must not settle to a fixed level in simulation
    always @(posedge hclk) begin
        float_q <= ~float_q;
    end

    initial float_q = 2'b01;

    // Device drive wins, then outside driver, then pulldown, else floating
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (pin_oe[i] === 1'b1) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pin_pulldown_en[i] === 1'b1) begin
                pin_in[i] = 1'b0;
            end else begin
                pin_in[i] = float_q[i];
            end
        end
    end
endmodule // port_b_board

`default_nettype wire

/* File: testbench/port_b_direction_pulldown_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module port_b_direction_pulldown_bench;
    import port_b_pkg::*;

    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        ce = 1'b1;
    logic        hresp;
    logic        resp;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic [1:0]  pin_in, pin_out, pin_oe, pin_pulldown_en;
    logic [1:0]  ext_en = 2'h0;
    logic [1:0]  ext_val = 2'h0;
    logic        strap = 1'b0;
    logic [7:0]  rd;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    always #2.5 hclk = ~hclk;

    port_b_direction_pulldown DUT (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pulldown_en(pin_pulldown_en), .reset_pulldown_disable_option(strap)
    );

    port_b_board board (
        .hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pulldown_en(pin_pulldown_en), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in)
    );

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Single word transfer; waits on hready, data taken at the closing edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        haddr <= addr_of(idx);
        do begin @(posedge hclk); end while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do begin @(posedge hclk); end while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
        resp = hresp;
        // Let the edge's register updates settle before anyone looks at pins
        #1;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(what, exp, rd);
        check("hresp", {7'h0, HRESP_OKAY}, {7'h0, resp});
    endtask

    task automatic do_reset(input logic opt);
        @(posedge hclk);
        hresetn <= 1'b0;
        strap <= opt;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        #1;
    endtask

    task automatic t_after_reset();
        check("pin_oe", 8'h00, {6'h0, pin_oe});
        check("pulldown", 8'h03, {6'h0, pin_pulldown_en});
        rd_chk("direction", IDX_DIR, 8'h00);
        $display("test after_reset done");
    endtask

    task automatic t_dir_store();
        bus(1'b1, IDX_DIR, 8'h33);
        rd_chk("direction", IDX_DIR, 8'h33);
        check("pin_oe", 8'h00, {6'h0, pin_oe});
        bus(1'b1, IDX_DIR, 8'h00);
        // Clock enable low freezes the bus too, so this write must be lost
        ce <= 1'b0;
        bus(1'b1, IDX_DIR, 8'h0c);
        ce <= 1'b1;
        check("pin_oe frozen", 8'h00, {6'h0, pin_oe});
        rd_chk("direction frozen", IDX_DIR, 8'h00);
        $display("test dir_store done");
    endtask

    task automatic t_output();
        bus(1'b1, IDX_DATA, 8'h0c);
        bus(1'b1, IDX_DIR, 8'h0c);
        check("pin_oe", 8'h03, {6'h0, pin_oe});
        check("pin_out", 8'h03, {6'h0, pin_out});
        check("pulldown", 8'h00, {6'h0, pin_pulldown_en});
        rd_chk("data", IDX_DATA, 8'h0c);
        $display("test output done");
    endtask

    task automatic t_input();
        ext_en <= 2'b10;
        ext_val <= 2'b00;
        bus(1'b1, IDX_DIR, 8'h04);
        rd_chk("data", IDX_DATA, 8'h04);
        ext_val <= 2'b10;
        rd_chk("data", IDX_DATA, 8'h0c);
        bus(1'b1, IDX_DATA, 8'h00);
        rd_chk("data", IDX_DATA, 8'h08);
        check("pin_out", 8'h00, {6'h0, pin_out});
        ext_en <= 2'b00;
        $display("test input done");
    endtask

    task automatic t_inhibit();
        bus(1'b1, IDX_DIR, 8'h00);
        bus(1'b1, IDX_PULL, 8'h04);
        check("pulldown", 8'h02, {6'h0, pin_pulldown_en});
        bus(1'b1, IDX_PULL, 8'h0c);
        check("pulldown", 8'h00, {6'h0, pin_pulldown_en});
        bus(1'b1, IDX_PULL, 8'h00);
        check("pulldown", 8'h03, {6'h0, pin_pulldown_en});
        rd_chk("inhibit", IDX_PULL, 8'h00);
        rd_chk("unmapped", 8'h30, 8'h00);
        $display("test inhibit done");
    endtask

    // Latch survives reset; strap keeps pulldowns off until software acts
    task automatic t_strap();
        bus(1'b1, IDX_DATA, 8'h0c);
        do_reset(1'b1);
        check("pin_oe", 8'h00, {6'h0, pin_oe});
        check("pulldown", 8'h00, {6'h0, pin_pulldown_en});
        rd_chk("direction", IDX_DIR, 8'h00);
        bus(1'b1, IDX_DIR, 8'h0c);
        check("pin_out", 8'h03, {6'h0, pin_out});
        bus(1'b1, IDX_DIR, 8'h00);
        bus(1'b1, IDX_PULL, 8'h00);
        check("pulldown", 8'h03, {6'h0, pin_pulldown_en});
        $display("test strap done");
    endtask

    initial begin
        do_reset(1'b0);
        t_after_reset();
        t_dir_store();
        t_output();
        t_input();
        t_inhibit();
        t_strap();
        stop_test();
    end
endmodule // port_b_direction_pulldown_bench

`default_nettype wire
